//--- verilog/charger_cfg_pkg.sv
// Functional notes
// - writing one to adc_go starts a conversion; reads one while converting or detecting
// - with adc_continuous_sel set, host writes to adc_go are ignored
// - adc_continuous_sel zero gives one-shot, one gives a conversion every second
// - sel_a zero selects 1.5MHz boost switching, one selects 500KHz
// - host writes to sel_a are dropped while otg_boost_on is set
// - input_optimizer_on runs the optimizer when one, reset value one
// - hv_port_handshake_on permits the high-voltage handshake, reset value one
// - adj_adapter_handshake_on permits adjustable adapter negotiation, reset value one
// - force_source_detect starts detection at once; reads zero when none runs
// - auto_source_detect_on runs detection on bus insertion, reset value one
// - data_select_drive drives data_select_pin low at zero, high at one
// - host writes one to watchdog_kick; device clears it back to zero
// - otg_boost_on enables boost mode at one, reset value zero
// - min_system_voltage is 3.0V plus 0.1V per step, reset code 101
// - boost exit threshold bit selects 2.9V at zero, 2.5V at one
// - pulse_ctrl_on allows pulse up and down commands, reset value zero
// - fast_charge_current is 64mA per step, reset 0100000; zero stops charging
// - fast_charge_current codes above 1001111 are clamped to 1001111
// - precharge and termination currents are 64mA plus 64mA per step
// - watchdog expiry restores defaults except the exempted fields
// - the bank answers on seven-bit target address 1101010
package charger_cfg_pkg;
  localparam logic [6:0]  I2C_TARGET_ADDR   = 7'h6a;
  localparam logic [7:0]  ADDR_ADC_DET      = 8'h02;
  localparam logic [7:0]  ADDR_MODE_SYS     = 8'h03;
  localparam logic [7:0]  ADDR_FCHG         = 8'h04;
  localparam logic [7:0]  ADDR_PRE_TERM     = 8'h05;
  localparam logic [7:0]  RST_ADC_DET       = 8'h1d;
  localparam logic [7:0]  RST_MODE_SYS      = 8'h1a;
  localparam logic [7:0]  RST_FCHG          = 8'h20;
  localparam logic [7:0]  RST_PRE_TERM      = 8'h13;
  localparam logic [7:0]  WD_MASK_ADC_DET   = 8'he2;
  localparam logic [7:0]  WD_MASK_MODE_SYS  = 8'h71;
  localparam logic [7:0]  WD_MASK_FCHG      = 8'hff;
  localparam logic [7:0]  WD_MASK_PRE_TERM  = 8'hff;
  localparam int          ADC_GO_BIT        = 7;
  localparam int          ADC_CONT_BIT      = 6;
  localparam int          SEL_A_BIT         = 5;
  localparam int          ICO_BIT           = 4;
  localparam int          HV_BIT            = 3;
  localparam int          ADJ_BIT           = 2;
  localparam int          FORCE_DET_BIT     = 1;
  localparam int          AUTO_DET_BIT      = 0;
  localparam int          DATA_SELECT_PIN_BIT          = 7;
  localparam int          KICK_BIT          = 6;
  localparam int          OTG_BIT           = 5;
  localparam int          CHG_BIT           = 4;
  localparam int          SYSMIN_MSB        = 3;
  localparam int          SYSMIN_LSB        = 1;
  localparam int          MINVBAT_BIT       = 0;
  localparam int          PULSE_BIT         = 7;
  localparam int          PRE_MSB           = 7;
  localparam int          PRE_LSB           = 4;
  localparam logic [6:0]  FAST_CHARGE_CURRENT_MAX          = 7'h4f;
  localparam int unsigned CLK_FREQ_HZ       = 200_000_000;
  localparam int unsigned ADC_PERIOD_MS     = 1000;
  localparam int unsigned ADC_PERIOD_CYCLES = CLK_FREQ_HZ / 1000 * ADC_PERIOD_MS;
endpackage : charger_cfg_pkg

//--- verilog/period_tick.sv
`timescale 1ns/1ps
module period_tick #(
  parameter int unsigned CYCLES = 1000
) (
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  input  wire logic run_in,
  output logic      tick_out
);
  logic [31:0] count_q;

  // counter restarts whenever the run level drops
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || !run_in) begin
      count_q <= 32'h0;
    end else if (count_q == 32'(CYCLES - 1)) begin
      count_q <= 32'h0;
    end else begin
      count_q <= count_q + 32'h1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= run_in && (count_q == 32'(CYCLES - 1));
    end
  end
endmodule : period_tick

//--- verilog/i2c_target.sv
`timescale 1ns/1ps
module i2c_target
  import charger_cfg_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  output logic            wr_en_out,
  output logic [7:0]      wr_addr_out,
  output logic [7:0]      wr_data_out,
  output logic [7:0]      rd_addr_out,
  input  wire logic [7:0] rd_data_in
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WRITE, ST_ACK_WR, ST_READ, ST_ACK_RD
  } i2c_state_e;

  i2c_state_e state_q;
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic       scl_prev_q;
  logic       sda_prev_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic       is_read_q;
  logic       have_ptr_q;
  logic       nack_q;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;

  // pins come from the bus, two flops before anything looks at them
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  assign scl_rise   = scl_sync_q[1] && !scl_prev_q;
  assign scl_fall   = !scl_sync_q[1] && scl_prev_q;
  assign start_cond = scl_sync_q[1] && scl_prev_q && sda_prev_q && !sda_sync_q[1];
  assign stop_cond  = scl_sync_q[1] && scl_prev_q && !sda_prev_q && sda_sync_q[1];

  always_ff @(posedge ref_clk_in) begin
    sda_out <= 1'b0;
    if (rst_in) begin
      state_q     <= ST_IDLE;
      bit_cnt_q   <= 4'h0;
      shift_q     <= 8'h00;
      is_read_q   <= 1'b0;
      have_ptr_q  <= 1'b0;
      nack_q      <= 1'b0;
      sda_oe_out  <= 1'b0;
      wr_en_out   <= 1'b0;
      wr_addr_out <= 8'h00;
      wr_data_out <= 8'h00;
      rd_addr_out <= 8'h00;
    end else begin
      wr_en_out <= 1'b0;
      if (start_cond) begin
        state_q    <= ST_ADDR;
        bit_cnt_q  <= 4'h0;
        have_ptr_q <= 1'b0;
        sda_oe_out <= 1'b0;
      end else if (stop_cond) begin
        state_q    <= ST_IDLE;
        sda_oe_out <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR, ST_WRITE: begin
            if (scl_rise) begin
              shift_q   <= {shift_q[6:0], sda_sync_q[1]};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == 4'h8) begin
              bit_cnt_q <= 4'h0;
              if (state_q == ST_ADDR) begin
                if (shift_q[7:1] == I2C_TARGET_ADDR) begin
                  is_read_q  <= shift_q[0];
                  sda_oe_out <= 1'b1;
                  state_q    <= ST_ACK_ADDR;
                end else begin
                  state_q <= ST_IDLE;
                end
              end else begin
                sda_oe_out <= 1'b1;
                state_q    <= ST_ACK_WR;
                if (have_ptr_q) begin
                  wr_en_out   <= 1'b1;
                  wr_addr_out <= rd_addr_out;
                  wr_data_out <= shift_q;
                  rd_addr_out <= rd_addr_out + 8'h1;
                end else begin
                  rd_addr_out <= shift_q;
                  have_ptr_q  <= 1'b1;
                end
              end
            end
          end
          ST_ACK_ADDR, ST_ACK_WR: begin
            if (scl_fall) begin
              if (state_q == ST_ACK_ADDR && is_read_q) begin
                sda_oe_out <= !rd_data_in[7];
                shift_q    <= {rd_data_in[6:0], 1'b0};
                bit_cnt_q  <= 4'h1;
                state_q    <= ST_READ;
              end else begin
                sda_oe_out <= 1'b0;
                state_q    <= ST_WRITE;
              end
            end
          end
          ST_READ: begin
            if (scl_fall) begin
              if (bit_cnt_q == 4'h8) begin
                sda_oe_out  <= 1'b0;
                rd_addr_out <= rd_addr_out + 8'h1;
                state_q     <= ST_ACK_RD;
              end else begin
                sda_oe_out <= !shift_q[7];
                shift_q    <= {shift_q[6:0], 1'b0};
                bit_cnt_q  <= bit_cnt_q + 4'h1;
              end
            end
          end
          ST_ACK_RD: begin
            if (scl_rise) begin
              nack_q <= sda_sync_q[1];
            end else if (scl_fall) begin
              if (nack_q) begin
                state_q <= ST_IDLE;
              end else begin
                sda_oe_out <= !rd_data_in[7];
                shift_q    <= {rd_data_in[6:0], 1'b0};
                bit_cnt_q  <= 4'h1;
                state_q    <= ST_READ;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule : i2c_target

//--- verilog/charger_config_registers.sv
`timescale 1ns/1ps
module charger_config_registers
  import charger_cfg_pkg::*;
#(
  parameter int unsigned ADC_PERIOD_CYC = ADC_PERIOD_CYCLES
) (
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_out,
  input  wire logic vbus_present_in,
  input  wire logic reg_reset_in,
  input  wire logic wd_expire_in,
  input  wire logic adc_done_in,
  input  wire logic detect_done_in,
  output logic      adc_start_out,
  output logic      adc_busy_out,
  output logic      detect_start_out,
  output logic      detect_busy_out,
  output logic      watchdog_kick_out,
  output logic      sel_a_out,
  output logic      input_optimizer_on_out,
  output logic      hv_port_handshake_on_out,
  output logic      adj_adapter_handshake_on_out,
  output logic      data_select_pin_out,
  output logic      otg_boost_on_out,
  output logic      charge_enable_out,
  output logic [2:0] min_system_voltage_out,
  output logic      boost_exit_low_out,
  output logic      pulse_ctrl_on_out,
  output logic [6:0] fast_charge_current_out,
  output logic [3:0] precharge_current_out,
  output logic [3:0] termination_current_out
);
  logic [7:0] r02_q;
  logic [7:0] r03_q;
  logic [7:0] r04_q;
  logic [7:0] r05_q;
  logic       conv_busy_q;
  logic       det_busy_q;
  logic [2:0] vbus_sync_q;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic       tick;
  logic       wr02;
  logic       wr03;
  logic       wr04;
  logic       wr05;
  logic       any_reset;
  logic       go_req;
  logic       cont_rise;
  logic       det_req;
  logic       vbus_rise;

  // restore the masked fields to default, keep the rest
  function automatic logic [7:0] wd_restore(input logic [7:0] cur,
                                            input logic [7:0] dflt,
                                            input logic [7:0] mask);
    wd_restore = (cur & ~mask) | (dflt & mask);
  endfunction : wd_restore

  function automatic logic [6:0] clamp_fast_charge_current(input logic [6:0] code);
    clamp_fast_charge_current = (code > FAST_CHARGE_CURRENT_MAX) ? FAST_CHARGE_CURRENT_MAX : code;
  endfunction : clamp_fast_charge_current

  i2c_target u_i2c (
    .ref_clk_in  (ref_clk_in),
    .rst_in      (rst_in),
    .scl_in      (scl_in),
    .sda_in      (sda_in),
    .sda_out     (sda_out),
    .sda_oe_out  (sda_oe_out),
    .wr_en_out   (wr_en),
    .wr_addr_out (wr_addr),
    .wr_data_out (wr_data),
    .rd_addr_out (rd_addr),
    .rd_data_in  (rd_data)
  );

  period_tick #(
    .CYCLES (ADC_PERIOD_CYC)
  ) u_tick (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .run_in     (r02_q[ADC_CONT_BIT]),
    .tick_out   (tick)
  );

  assign wr02      = wr_en && (wr_addr == ADDR_ADC_DET);
  assign wr03      = wr_en && (wr_addr == ADDR_MODE_SYS);
  assign wr04      = wr_en && (wr_addr == ADDR_FCHG);
  assign wr05      = wr_en && (wr_addr == ADDR_PRE_TERM);
  assign any_reset = reg_reset_in || wd_expire_in;
  // go only honoured in one-shot mode
  assign go_req    = wr02 && wr_data[ADC_GO_BIT] && !r02_q[ADC_CONT_BIT];
  assign cont_rise = wr02 && wr_data[ADC_CONT_BIT] && !r02_q[ADC_CONT_BIT];
  assign vbus_rise = vbus_sync_q[1] && !vbus_sync_q[2];
  assign det_req   = (wr02 && wr_data[FORCE_DET_BIT])
                     || (vbus_rise && r02_q[AUTO_DET_BIT]);

  // bus sense is a pin, synchronise before edge detection
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      vbus_sync_q <= 3'h0;
    end else begin
      vbus_sync_q <= {vbus_sync_q[1:0], vbus_present_in};
    end
  end

  // conversion busy, start wins over done
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || any_reset) begin
      conv_busy_q   <= 1'b0;
      adc_start_out <= 1'b0;
    end else begin
      adc_start_out <= go_req || cont_rise || tick;
      if (go_req || cont_rise || tick) begin
        conv_busy_q <= 1'b1;
      end else if (adc_done_in) begin
        conv_busy_q <= 1'b0;
      end
    end
  end

  // detection busy, start wins over done
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || any_reset) begin
      det_busy_q       <= 1'b0;
      detect_start_out <= 1'b0;
    end else begin
      detect_start_out <= det_req;
      if (det_req) begin
        det_busy_q <= 1'b1;
      end else if (detect_done_in) begin
        det_busy_q <= 1'b0;
      end
    end
  end

  // go and force bits are not stored, they read back the busy flags
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || reg_reset_in) begin
      r02_q <= RST_ADC_DET;
    end else if (wd_expire_in) begin
      r02_q <= wd_restore(r02_q, RST_ADC_DET, WD_MASK_ADC_DET);
    end else if (wr02) begin
      r02_q <= wr_data;
      r02_q[ADC_GO_BIT]    <= 1'b0;
      r02_q[FORCE_DET_BIT] <= 1'b0;
      if (r03_q[OTG_BIT]) begin
        r02_q[SEL_A_BIT] <= r02_q[SEL_A_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || reg_reset_in) begin
      r03_q <= RST_MODE_SYS;
    end else if (wd_expire_in) begin
      r03_q <= wd_restore(r03_q, RST_MODE_SYS, WD_MASK_MODE_SYS);
    end else if (wr03) begin
      r03_q <= wr_data;
    end else begin
      r03_q[KICK_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || reg_reset_in) begin
      r04_q <= RST_FCHG;
    end else if (wd_expire_in) begin
      r04_q <= wd_restore(r04_q, RST_FCHG, WD_MASK_FCHG);
    end else if (wr04) begin
      r04_q <= {wr_data[PULSE_BIT], clamp_fast_charge_current(wr_data[6:0])};
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || reg_reset_in) begin
      r05_q <= RST_PRE_TERM;
    end else if (wd_expire_in) begin
      r05_q <= wd_restore(r05_q, RST_PRE_TERM, WD_MASK_PRE_TERM);
    end else if (wr05) begin
      r05_q <= wr_data;
    end
  end

  // unmapped offsets read as zero, writes to them vanish
  always_comb begin
    case (rd_addr)
      ADDR_ADC_DET:  rd_data = r02_q | {conv_busy_q || det_busy_q, 5'h00, det_busy_q, 1'b0};
      ADDR_MODE_SYS: rd_data = r03_q;
      ADDR_FCHG:     rd_data = r04_q;
      ADDR_PRE_TERM: rd_data = r05_q;
      default:       rd_data = 8'h00;
    endcase
  end

  assign adc_busy_out                 = conv_busy_q;
  assign detect_busy_out              = det_busy_q;
  assign watchdog_kick_out            = r03_q[KICK_BIT];
  assign sel_a_out                    = r02_q[SEL_A_BIT];
  assign input_optimizer_on_out       = r02_q[ICO_BIT];
  assign hv_port_handshake_on_out     = r02_q[HV_BIT];
  assign adj_adapter_handshake_on_out = r02_q[ADJ_BIT];
  assign data_select_pin_out          = r03_q[DATA_SELECT_PIN_BIT];
  assign otg_boost_on_out             = r03_q[OTG_BIT];
  assign min_system_voltage_out       = r03_q[SYSMIN_MSB:SYSMIN_LSB];
  assign boost_exit_low_out           = r03_q[MINVBAT_BIT];
  assign pulse_ctrl_on_out            = r04_q[PULSE_BIT];
  assign fast_charge_current_out      = r04_q[6:0];
  assign precharge_current_out        = r05_q[PRE_MSB:PRE_LSB];
  assign termination_current_out      = r05_q[3:0];

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      charge_enable_out <= 1'b0;
    end else begin
      charge_enable_out <= r03_q[CHG_BIT] && (r04_q[6:0] != 7'h00);
    end
  end

  sequence s_go_write;
    wr02 && wr_data[ADC_GO_BIT] && !r02_q[ADC_CONT_BIT] && !any_reset;
  endsequence

  // busy is held by the ticks in continuous mode, so only the start pulse is watched
  sequence s_quiet_go_cont;
    wr02 && wr_data[ADC_GO_BIT] && r02_q[ADC_CONT_BIT] && !tick;
  endsequence

  AST_GO_STARTS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    s_go_write |=> conv_busy_q && adc_start_out && rd_data_of_go())
    else $error("go write did not start a conversion");

  AST_CONT_IGNORES_GO: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    s_quiet_go_cont |=> !adc_start_out)
    else $error("go write honoured in continuous mode");

  AST_TICK_REPEATS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    tick && r02_q[ADC_CONT_BIT] && !any_reset |=> conv_busy_q)
    else $error("continuous tick did not start a conversion");

  AST_SELA_LOCK: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    wr02 && r03_q[OTG_BIT] && !any_reset |=> $stable(r02_q[SEL_A_BIT]))
    else $error("frequency select changed during boost");

  AST_DETECT_FORCE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    wr02 && wr_data[FORCE_DET_BIT] && !any_reset |=> det_busy_q ##0 rd_data_of_det())
    else $error("forced detection did not start");

  AST_KICK_CLEARS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    r03_q[KICK_BIT] && !wr03 |=> !watchdog_kick_out)
    else $error("watchdog kick not cleared");

  AST_FAST_CHARGE_CURRENT_CLAMP: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    wr04 && !any_reset |=> fast_charge_current_out == clamp_fast_charge_current($past(wr_data[6:0])))
    else $error("fast charge code not clamped");

  AST_ZERO_STOPS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    r04_q[6:0] == 7'h00 |=> !charge_enable_out)
    else $error("charging enabled with zero current");

  AST_WD_DEFAULTS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    wd_expire_in && !reg_reset_in |=> r04_q == RST_FCHG && r05_q == RST_PRE_TERM
      && !conv_busy_q && !otg_boost_on_out)
    else $error("watchdog did not restore defaults");

  AST_WD_KEEPS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    wd_expire_in && !reg_reset_in |=> $stable(r02_q[ICO_BIT:ADJ_BIT])
      && $stable(r03_q[SYSMIN_MSB:SYSMIN_LSB]) && $stable(data_select_pin_out))
    else $error("exempt field changed on watchdog");

  function automatic logic rd_data_of_go();
    rd_data_of_go = (rd_addr != ADDR_ADC_DET) || rd_data[ADC_GO_BIT];
  endfunction : rd_data_of_go

  function automatic logic rd_data_of_det();
    rd_data_of_det = (rd_addr != ADDR_ADC_DET) || rd_data[FORCE_DET_BIT];
  endfunction : rd_data_of_det
endmodule : charger_config_registers

//--- sim/i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model
  import charger_cfg_pkg::*;
(
  input  wire logic ref_clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_pull_out
);
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  // six clocks a phase keeps both scl phases above the four the target needs
  task automatic phase(input logic scl, input logic pull);
    @(posedge ref_clk_in);
    scl_out <= scl;
    sda_pull_out <= pull;
    repeat (5) @(posedge ref_clk_in);
  endtask : phase
  // sda moves while scl is high only for the start and stop edges, so no false start or stop
  task automatic start_cond();
    phase(1'b0, sda_pull_out);
    phase(1'b0, 1'b0);
    phase(1'b1, 1'b0);
    phase(1'b1, 1'b1);
    phase(1'b0, 1'b1);
  endtask : start_cond
  task automatic stop_cond();
    phase(1'b0, sda_pull_out);
    phase(1'b0, 1'b1);
    phase(1'b1, 1'b1);
    phase(1'b1, 1'b0);
  endtask : stop_cond
  task automatic xfer(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
                      inout logic nack);
    logic [8:0] w;
    logic [8:0] r;
    w = {tx, ack_tx};
    for (int i = 8; i >= 0; i--) begin
      phase(1'b0, sda_pull_out);
      phase(1'b0, !w[i]);
      phase(1'b1, !w[i]);
      r[i] = sda_in;
    end
    rx = r[8:1];
    nack = nack | r[0];
  endtask : xfer
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] data,
                           output logic nack);
    logic [7:0] rx;
    nack = 1'b0;
    start_cond();
    xfer({dev, 1'b0}, 1'b1, rx, nack);
    xfer(ptr, 1'b1, rx, nack);
    xfer(data, 1'b1, rx, nack);
    stop_cond();
  endtask : write_reg
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data, output logic nack);
    logic own;
    nack = 1'b0;
    own = 1'b0;
    start_cond();
    xfer({I2C_TARGET_ADDR, 1'b0}, 1'b1, data, nack);
    xfer(ptr, 1'b1, data, nack);
    start_cond();
    xfer({I2C_TARGET_ADDR, 1'b1}, 1'b1, data, nack);
    xfer(8'hff, 1'b1, data, own);
    stop_cond();
  endtask : read_reg
endmodule : i2c_host_model

//--- sim/tb.sv
`timescale 1ns/1ps
module tb;
  import charger_cfg_pkg::*;
  logic       ref_clk_in = 1'b0;
  logic       rst_in     = 1'b1;
  logic [4:0] ctl        = 5'h00;
  logic [7:0] adc_n      = 8'h00;
  logic [7:0] det_n      = 8'h00;
  logic [7:0] kick_n     = 8'h00;
  int         mismatches = 0;
  int         tests_run  = 0;
  int         cycles     = 0;
  logic       scl, pull, sda_oe, sda_o, adc_st, det_st, kick, sel_a, data_select_pin, chg, pls, bsy;
  logic       adc_bsy, ico, hv, adj, otg, bxl;
  logic [3:0] pre, term;
  logic [2:0] sysmin;
  logic [6:0] fcc;
  // open drain with pull-up: released means high
  wire        sda = !((sda_oe && !sda_o) || pull);
  charger_config_registers #(.ADC_PERIOD_CYC(50)) charger_config_registers_inst (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .vbus_present_in(ctl[4]), .reg_reset_in(ctl[3]),
    .wd_expire_in(ctl[2]), .adc_done_in(ctl[1]), .detect_done_in(ctl[0]),
    .adc_start_out(adc_st), .adc_busy_out(adc_bsy), .detect_start_out(det_st),
    .detect_busy_out(bsy), .watchdog_kick_out(kick), .sel_a_out(sel_a),
    .input_optimizer_on_out(ico), .hv_port_handshake_on_out(hv),
    .adj_adapter_handshake_on_out(adj),
    .data_select_pin_out(data_select_pin), .otg_boost_on_out(otg), .charge_enable_out(chg),
    .min_system_voltage_out(sysmin), .boost_exit_low_out(bxl), .pulse_ctrl_on_out(pls),
    .fast_charge_current_out(fcc), .precharge_current_out(pre),
    .termination_current_out(term));
  i2c_host_model i2c_host_model_inst (
    .ref_clk_in(ref_clk_in), .sda_in(sda), .scl_out(scl), .sda_pull_out(pull));
  always #2.5 ref_clk_in = ~ref_clk_in;
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  always @(posedge ref_clk_in) begin
    adc_n <= adc_n + 8'(adc_st);
    det_n <= det_n + 8'(det_st);
    kick_n <= kick_n + 8'(kick);
    cycles <= cycles + 1;
    // the whole sequence needs about 24600 cycles
    if (cycles == 70000) begin
      mismatches = mismatches + 1;
      test_done();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic chk1(input string what, input logic seen, input logic exp);
    check(what, {7'h00, seen}, {7'h00, exp});
  endtask : chk1
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic nack;
    i2c_host_model_inst.write_reg(I2C_TARGET_ADDR, a, d, nack);
    chk1("write ack", nack, 1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       nack;
    i2c_host_model_inst.read_reg(a, d, nack);
    chk1("read ack", nack, 1'b0);
    check("register", d, exp);
  endtask : rd
  task automatic regs4(input logic [31:0] e);
    for (int i = 0; i < 4; i++) rd(8'h02 + 8'(i), e[31-8*i -: 8]);
  endtask : regs4
  task automatic pulse(input int i);
    @(posedge ref_clk_in);
    ctl[i] <= 1'b1;
    @(posedge ref_clk_in);
    ctl[i] <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
  endtask : pulse
  initial begin
    logic       nack;
    logic [7:0] n;
    repeat (4) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    regs4(32'h1d1a2013);
    chk1("charge enable", chg, 1'b1);
    check("optimizer hv adj", {5'h00, ico, hv, adj}, 8'h07);
    chk1("otg default", otg, 1'b0);
    i2c_host_model_inst.write_reg(7'h6b, 8'h04, 8'h00, nack);
    chk1("foreign address nack", nack, 1'b1);
    rd(8'h07, 8'h00);
    n = adc_n;
    wr(8'h02, 8'h9d);
    check("one-shot starts", adc_n - n, 8'h01);
    chk1("adc busy", adc_bsy, 1'b1);
    rd(8'h02, 8'h9d);
    pulse(1);
    chk1("adc idle", adc_bsy, 1'b0);
    rd(8'h02, 8'h1d);
    wr(8'h02, 8'h5d);
    n = adc_n;
    repeat (500) @(posedge ref_clk_in);
    check("continuous starts", adc_n - n, 8'h0a);
    wr(8'h02, 8'hdd);
    rd(8'h02, 8'hdd);
    wr(8'h02, 8'h1d);
    pulse(1);
    n = det_n;
    ctl[4] <= 1'b1;
    repeat (10) @(posedge ref_clk_in);
    chk1("detect busy", bsy, 1'b1);
    rd(8'h02, 8'h9f);
    pulse(0);
    rd(8'h02, 8'h1d);
    ctl[4] <= 1'b0;
    wr(8'h02, 8'h1f);
    check("detect starts", det_n - n, 8'h02);
    pulse(0);
    wr(8'h03, 8'h3a);
    chk1("otg on", otg, 1'b1);
    wr(8'h02, 8'h3d);
    rd(8'h02, 8'h1d);
    wr(8'h03, 8'h1a);
    wr(8'h02, 8'h3d);
    chk1("sel_a", sel_a, 1'b1);
    n = kick_n;
    wr(8'h03, 8'h5a);
    check("kicks", kick_n - n, 8'h01);
    rd(8'h03, 8'h1a);
    wr(8'h03, 8'h9f);
    chk1("data select", data_select_pin, 1'b1);
    chk1("boost exit low", bxl, 1'b1);
    check("sysmin", {5'h00, sysmin}, 8'h07);
    wr(8'h04, 8'hff);
    rd(8'h04, 8'hcf);
    chk1("pulse ctrl", pls, 1'b1);
    check("fast charge", {1'b0, fcc}, 8'h4f);
    wr(8'h05, 8'h44);
    check("pre and term", {pre, term}, 8'h44);
    wr(8'h04, 8'h00);
    chk1("charge stop", chg, 1'b0);
    wr(8'h02, 8'h20);
    check("optimizer hv adj off", {5'h00, ico, hv, adj}, 8'h00);
    n = det_n;
    ctl[4] <= 1'b1;
    repeat (10) @(posedge ref_clk_in);
    check("no auto detect", det_n - n, 8'h00);
    pulse(2);
    regs4(32'h009e2013);
    pulse(3);
    regs4(32'h1d1a2013);
    test_done();
  end
endmodule : tb
